// >>> rtl/pfc_ctrl.sv
/*
 * PFC switch control and protection supervisor with an APB register file.
 * Assumes sense comparators and ADC words come from outside pclk and are
 * synchronised here; the resonant stage reads llc_enable.
 */
// Notes on behaviour
// - Next stroke only after demag and valley
// - Soft start ramps on-time limit per cycle
// - Digital loop sets on-time from boost error
// - Mains term scales loop gain constant
// - Switch on only after demagnetisation detected
// - Substitute valley after valley timeout
// - Above max frequency fall back to DCM
// - Enforce minimum off-time every cycle
// - No mains rise for delay: discharge
// - Stop discharge when mains reappears
// - Parameter load failure holds off, retries
// - Brownout stops PFC; LLC stop selectable
// - Drain overvoltage: stop, latch or restart
// - Overcurrent ends cycle, continue, record
// - Shorted coil: stop both, safe restart
// - Capacitive guard activity recorded
// - Listed faults: stop, latch or restart
// - In protection regulate supply via drain
// - Overcurrent for 100 ms means shorted coil
// - Blank overcurrent 300 ns after turn-on
`timescale 1ns/1ps
module pfc_ctrl #(
   parameter int SHORT_COIL_CYC = pfc_pkg::SHORT_COIL_CYC
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog front end (asynchronous)
   input wire logic [11:0] boost_sense_input,
   input wire logic [11:0] mains_sense_input,
   input wire logic pfc_current_sense,
   input wire logic pfc_drain_sense,
   input wire logic demag_detect,
   input wire logic ocp_trip,
   input wire logic brownout_flag,
   input wire logic brownin_flag,
   input wire logic drain_ovp_flag,
   input wire logic fault_flags_any,
   input wire logic cmr_active,
   input wire logic supply_below_start,
   // Parameter store
   input wire logic nvm_done,
   input wire logic nvm_ok,
   output logic nvm_read,
   // Outputs
   output logic pfc_gate,
   output logic llc_enable,
   output logic xcap_discharge,
   output logic supply_charge
);
   // ************************************************************
   // Synchronisers
   // ************************************************************
   localparam int NS = 11;
   logic [NS-1:0] raw_in;
   logic [NS-1:0] s1_reg;
   logic [NS-1:0] s2_reg;
   logic [11:0] boost_s1_reg, boost_s2_reg, mains_s1_reg, mains_s2_reg;

   assign raw_in = {pfc_current_sense, pfc_drain_sense, demag_detect, ocp_trip,
      brownout_flag, brownin_flag, drain_ovp_flag, fault_flags_any, cmr_active,
      supply_below_start, nvm_ok};

   // Two stages per bit; the ADC words are assumed stable between conversions
   generate
      for (genvar i = 0; i < NS; i++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_reg[i] <= 1'b0;
               s2_reg[i] <= 1'b0;
            end else begin
               s1_reg[i] <= raw_in[i];
               s2_reg[i] <= s1_reg[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boost_s1_reg <= 12'h000;
         boost_s2_reg <= 12'h000;
         mains_s1_reg <= 12'h000;
         mains_s2_reg <= 12'h000;
      end else begin
         boost_s1_reg <= boost_sense_input;
         boost_s2_reg <= boost_s1_reg;
         mains_s1_reg <= mains_sense_input;
         mains_s2_reg <= mains_s1_reg;
      end
   end

   logic cur_s, drn_s, demag_s, ocp_s, bo_s, bi_s, dovp_s, flt_s, cmr_s, sup_low_s, nvm_ok_s;
   assign {cur_s, drn_s, demag_s, ocp_s, bo_s, bi_s, dovp_s, flt_s, cmr_s, sup_low_s,
      nvm_ok_s} = s2_reg;

   // ************************************************************
   // Registers and APB
   // ************************************************************
   logic [3:0] ctrl_reg;
   logic [11:0] ref_reg;
   logic [15:0] offmin_reg;
   logic [15:0] permin_reg;
   logic [23:0] xcapdly_reg;
   logic [3:0] gain_reg;
   logic [pfc_pkg::PROT_W-1:0] prot_reg;
   logic [pfc_pkg::PROT_W-1:0] prot_set;
   logic wr_en, rd_hit;
   logic [31:0] rd_mux;

   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;
   assign rd_hit = (paddr <= pfc_pkg::ADDR_TON) && (paddr[1:0] == 2'b00);
   assign pslverr = psel && penable && !rd_hit;

   // Plain register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= pfc_pkg::CTRL_RST;
         ref_reg <= pfc_pkg::REF_RST;
         offmin_reg <= pfc_pkg::OFFMIN_RST;
         permin_reg <= pfc_pkg::PERMIN_RST;
         xcapdly_reg <= pfc_pkg::XCAPDLY_RST;
         gain_reg <= pfc_pkg::GAIN_RST;
      end else if (wr_en) begin
         if (paddr == pfc_pkg::ADDR_CTRL) ctrl_reg <= pwdata[3:0];
         if (paddr == pfc_pkg::ADDR_REF) ref_reg <= pwdata[11:0];
         if (paddr == pfc_pkg::ADDR_OFFMIN) offmin_reg <= pwdata[15:0];
         if (paddr == pfc_pkg::ADDR_PERMIN) permin_reg <= pwdata[15:0];
         if (paddr == pfc_pkg::ADDR_XCAPDLY) xcapdly_reg <= pwdata[23:0];
         if (paddr == pfc_pkg::ADDR_GAIN) gain_reg <= pwdata[3:0];
      end
   end

   // Protection flags: hardware set wins over a write-one clear
   logic prot_clr_en;
   assign prot_clr_en = wr_en && (paddr == pfc_pkg::ADDR_PROT);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prot_reg <= '0;
      else prot_reg <= (prot_reg & ~(prot_clr_en ? pwdata[pfc_pkg::PROT_W-1:0] : '0)) | prot_set;
   end

   // ************************************************************
   // Supervisor
   // ************************************************************
   pfc_pkg::pfc_sup_t sup_reg, sup_next;
   logic [23:0] coil_cnt_reg;
   logic coil_short;
   logic dovp_evt, flt_evt, fault_clear, latch_sel;
   logic nvm_fail;
   logic pfc_bo_reg;

   assign nvm_fail = nvm_done && !nvm_ok_s;
   // Overcurrent seen continuously for the long window means a shorted coil
   assign coil_short = (coil_cnt_reg == 24'(SHORT_COIL_CYC - 1));
   assign dovp_evt = dovp_s;
   assign flt_evt = flt_s;
   assign fault_clear = !dovp_s && !flt_s && !ocp_s;
   assign latch_sel = dovp_evt ? ctrl_reg[pfc_pkg::CTRL_OVP_LATCH_BIT] :
      ctrl_reg[pfc_pkg::CTRL_FLT_LATCH_BIT];

   // Next state
   always_comb begin
      sup_next = sup_reg;
      case (sup_reg)
         pfc_pkg::SUP_LOAD: if (nvm_done && nvm_ok_s) sup_next = pfc_pkg::SUP_RUN;
         pfc_pkg::SUP_RUN: begin
            if (coil_short) sup_next = pfc_pkg::SUP_RESTART;
            else if (dovp_evt || flt_evt)
               sup_next = latch_sel ? pfc_pkg::SUP_LATCH : pfc_pkg::SUP_RESTART;
         end
         // Restart re-enters the start-up sequence once faults are gone
         pfc_pkg::SUP_RESTART: if (fault_clear) sup_next = pfc_pkg::SUP_LOAD;
         pfc_pkg::SUP_LATCH: sup_next = pfc_pkg::SUP_LATCH;
         default: sup_next = pfc_pkg::SUP_LOAD;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sup_reg <= pfc_pkg::SUP_LOAD;
      else sup_reg <= sup_next;
   end

   // Parameter read request while loading; retried every cycle until valid
   assign nvm_read = (sup_reg == pfc_pkg::SUP_LOAD);

   // Brownout stops the PFC until brownin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pfc_bo_reg <= 1'b0;
      else if (bo_s) pfc_bo_reg <= 1'b1;
      else if (bi_s) pfc_bo_reg <= 1'b0;
   end

   // ************************************************************
   // On-time loop and soft start
   // ************************************************************
   pfc_sw_if sw();
   logic signed [13:0] err;
   logic signed [23:0] integ_reg;
   logic [11:0] ton_reg, ss_reg;
   logic [11:0] ton_loop;
   logic [3:0] mains_shift;
   logic run_ok;

   assign run_ok = (sup_reg == pfc_pkg::SUP_RUN) && ctrl_reg[pfc_pkg::CTRL_EN_BIT] &&
      !pfc_bo_reg && !sup_low_s;
   assign err = 14'(signed'({2'b00, ref_reg})) - 14'(signed'({2'b00, boost_s2_reg}));
   // Higher mains means less gain; the mains MSBs set a shift
   assign mains_shift = gain_reg + {2'b00, mains_s2_reg[11:10]};
   assign ton_loop = (integ_reg < 0) ? 12'h000 :
      ((integ_reg[23:12] != 12'h000) ? 12'hFFF : integ_reg[11:0]);

   // Integrator only, no proportional term, updated once per switching cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         integ_reg <= 24'sh000000;
         ton_reg <= 12'h000;
      end else if (sw.cycle_start) begin
         integ_reg <= integ_reg + (24'(err) >>> mains_shift);
         ton_reg <= ton_loop;
      end
   end

   // Soft start: limit climbs one step per cycle from zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ss_reg <= 12'h000;
      else if (!run_ok) ss_reg <= 12'h000;
      else if (sw.cycle_start && ss_reg < ton_reg) ss_reg <= ss_reg + 12'h001;
   end

   assign sw.run = run_ok;
   assign sw.ton_lim = (ss_reg < ton_reg) ? ss_reg : ton_reg;
   assign sw.off_min = offmin_reg;
   assign sw.per_min = permin_reg;
   assign sw.ocp_hit = ocp_s || cur_s;

   pfc_valley u_valley (
      .pclk(pclk),
      .presetn(presetn),
      .gate(sw.gate),
      .demag(demag_s),
      .valley(drn_s),
      .valley_ok(sw.valley_ok)
   );

   pfc_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .sw(sw)
   );

   // Continuous overcurrent counter, cleared by any cycle without a trip
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) coil_cnt_reg <= 24'h000000;
      else if (!ocp_s || sup_reg != pfc_pkg::SUP_RUN) coil_cnt_reg <= 24'h000000;
      else if (!coil_short) coil_cnt_reg <= coil_cnt_reg + 24'h000001;
   end

   // ************************************************************
   // X-capacitor discharge
   // ************************************************************
   logic [11:0] mains_max_reg;
   logic [23:0] xcap_cnt_reg;
   logic mains_rise;
   logic xcap_reg;
   assign mains_rise = mains_s2_reg > mains_max_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mains_max_reg <= 12'h000;
         xcap_cnt_reg <= 24'h000000;
         xcap_reg <= 1'b0;
      end else if (mains_rise) begin
         mains_max_reg <= mains_s2_reg;
         xcap_cnt_reg <= 24'h000000;
         xcap_reg <= 1'b0;
      end else if (xcap_cnt_reg >= xcapdly_reg) begin
         xcap_reg <= 1'b1;
         mains_max_reg <= mains_s2_reg;
      end else begin
         xcap_cnt_reg <= xcap_cnt_reg + 24'h000001;
      end
   end

   // ************************************************************
   // Outputs and readback
   // ************************************************************
   assign prot_set = {coil_short, flt_evt && sup_reg == pfc_pkg::SUP_RUN, cmr_s,
      sw.cycle_ocp, dovp_evt && sup_reg == pfc_pkg::SUP_RUN,
      nvm_fail && sup_reg == pfc_pkg::SUP_LOAD};
   assign pfc_gate = sw.gate;
   assign llc_enable = (sup_reg == pfc_pkg::SUP_RUN) &&
      !(pfc_bo_reg && ctrl_reg[pfc_pkg::CTRL_BO_LLC_BIT]);
   assign xcap_discharge = xcap_reg;
   assign supply_charge = (sup_reg == pfc_pkg::SUP_LATCH || sup_reg == pfc_pkg::SUP_RESTART
      || sup_reg == pfc_pkg::SUP_LOAD) && sup_low_s;

   assign rd_mux = (paddr == pfc_pkg::ADDR_CTRL) ? {28'h0, ctrl_reg} :
      (paddr == pfc_pkg::ADDR_REF) ? {20'h0, ref_reg} :
      (paddr == pfc_pkg::ADDR_OFFMIN) ? {16'h0, offmin_reg} :
      (paddr == pfc_pkg::ADDR_PERMIN) ? {16'h0, permin_reg} :
      (paddr == pfc_pkg::ADDR_XCAPDLY) ? {8'h0, xcapdly_reg} :
      (paddr == pfc_pkg::ADDR_GAIN) ? {28'h0, gain_reg} :
      (paddr == pfc_pkg::ADDR_PROT) ? {26'h0, prot_reg} :
      (paddr == pfc_pkg::ADDR_STATUS) ? {25'h0, xcap_reg, pfc_bo_reg, sw.gate, 1'b0, sup_reg} :
      (paddr == pfc_pkg::ADDR_TON) ? {20'h0, sw.ton_lim} : 32'h0;

   // Registered read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0;
      else if (psel && !penable && !pwrite) prdata <= rd_mux;
   end

   a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
      sup_reg == pfc_pkg::SUP_LATCH |=> sup_reg == pfc_pkg::SUP_LATCH)
      else $error("latched protection released");
   a_no_gate_prot: assert property (@(posedge pclk) disable iff (!presetn)
      sup_reg != pfc_pkg::SUP_RUN |-> !sw.run ##1 !$rose(pfc_gate))
      else $error("gate rose while protection active");
   a_coil_trip: assert property (@(posedge pclk) disable iff (!presetn)
      coil_short && sup_reg == pfc_pkg::SUP_RUN |=> sup_reg == pfc_pkg::SUP_RESTART)
      else $error("coil short did not restart");
   a_nvm_hold: assert property (@(posedge pclk) disable iff (!presetn)
      sup_reg == pfc_pkg::SUP_LOAD |-> !llc_enable && !sw.run)
      else $error("converters on during parameter load");
   a_ss_step: assert property (@(posedge pclk) disable iff (!presetn)
      run_ok && $past(run_ok) |-> ss_reg - $past(ss_reg) <= 12'h001)
      else $error("soft start stepped more than one");
   a_xcap_off: assert property (@(posedge pclk) disable iff (!presetn)
      mains_rise |=> !xcap_discharge)
      else $error("discharge stayed on with mains present");
   a_ocp_flag: assert property (@(posedge pclk) disable iff (!presetn)
      sw.cycle_ocp |=> prot_reg[pfc_pkg::PROT_OCP_BIT])
      else $error("overcurrent not recorded");
endmodule

// >>> rtl/pfc_pkg.sv
/*
 * Package for the PFC switch control and protection block: the register map,
 * the field positions, the reset values, the timing counts and the supervisor states.
 * Assumes a 20 MHz pclk. Every user writes pfc_pkg::name and imports nothing.
 */
package pfc_pkg;
   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int CLK_MHZ = 20;
   localparam int VALLEY_TIMEOUT_US = 10;
   localparam int VALLEY_TIMEOUT_CYC = (VALLEY_TIMEOUT_US * CLK_MHZ);
   localparam int BLANK_NS = 300;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int SHORT_COIL_MS = 100;
   localparam int SHORT_COIL_CYC = SHORT_COIL_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 24;
   localparam int TON_W = 12;
   localparam int ADC_W = 12;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_REF = 8'h04;
   localparam logic [7:0] ADDR_OFFMIN = 8'h08;
   localparam logic [7:0] ADDR_PERMIN = 8'h0C;
   localparam logic [7:0] ADDR_XCAPDLY = 8'h10;
   localparam logic [7:0] ADDR_GAIN = 8'h14;
   localparam logic [7:0] ADDR_PROT = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_TON = 8'h20;

   // Control register fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_OVP_LATCH_BIT = 1;
   localparam int CTRL_FLT_LATCH_BIT = 2;
   localparam int CTRL_BO_LLC_BIT = 3;

   // Protection register fields, write one to clear
   localparam int PROT_NVM_BIT = 0;
   localparam int PROT_DOVP_BIT = 1;
   localparam int PROT_OCP_BIT = 2;
   localparam int PROT_CMR_BIT = 3;
   localparam int PROT_FLT_BIT = 4;
   localparam int PROT_COIL_BIT = 5;
   localparam int PROT_W = 6;

   // Reset values
   localparam logic [3:0] CTRL_RST = 4'h1;
   localparam logic [ADC_W-1:0] REF_RST = 12'h800;
   localparam logic [15:0] OFFMIN_RST = 16'h0014;
   localparam logic [15:0] PERMIN_RST = 16'h0064;
   localparam logic [CNT_W-1:0] XCAPDLY_RST = 24'h030D40;
   localparam logic [3:0] GAIN_RST = 4'h4;

   // Supervisor states
   typedef enum logic [2:0] {SUP_LOAD, SUP_RUN, SUP_RESTART, SUP_LATCH} pfc_sup_t;
endpackage

// >>> rtl/pfc_sw_if.sv
/*
 * Interface carrying the switch-cycle events between the control core and the
 * cycle timer. Both ends run on the same pclk.
 */
`timescale 1ns/1ps
interface pfc_sw_if;
   logic gate;
   logic run;
   logic [pfc_pkg::TON_W-1:0] ton_lim;
   logic [15:0] off_min;
   logic [15:0] per_min;
   logic valley_ok;
   logic ocp_hit;
   logic cycle_start;
   logic cycle_ocp;
   modport core (output run, ton_lim, off_min, per_min, valley_ok, ocp_hit,
      input gate, cycle_start, cycle_ocp);
   modport timer (input run, ton_lim, off_min, per_min, valley_ok, ocp_hit,
      output gate, cycle_start, cycle_ocp);
endinterface

// >>> rtl/pfc_valley.sv
/*
 * Valley gate: qualifies the turn-on moment after demagnetisation, from a real
 * valley or from the timeout. Inputs arrive already synchronised on pclk.
 */
`timescale 1ns/1ps
module pfc_valley (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Sense events
   input wire logic gate,
   input wire logic demag,
   input wire logic valley,
   // Result
   output logic valley_ok
);
   logic armed_reg;
   logic [7:0] tmo_reg;
   logic tmo_done;

   // Substitute valley once the timeout has run out
   assign tmo_done = (tmo_reg == 8'(pfc_pkg::VALLEY_TIMEOUT_CYC));

   // Arm on demagnetisation while the switch is off, reset on turn-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_reg <= 1'b0;
         tmo_reg <= 8'h00;
      end else if (gate) begin
         armed_reg <= 1'b0;
         tmo_reg <= 8'h00;
      end else begin
         if (demag) armed_reg <= 1'b1;
         if ((armed_reg || demag) && !tmo_done) tmo_reg <= tmo_reg + 8'h01;
      end
   end

   // Turn-on is allowed only once demagnetised and at a valley or after the timeout
   assign valley_ok = armed_reg && (valley || tmo_done);

   // Armed with no real valley, then the timeout runs out
   sequence s_armed_wait;
      (armed_reg && !gate && !valley) ##1 tmo_done;
   endsequence

   a_valley_tmo: assert property (@(posedge pclk) disable iff (!presetn)
      s_armed_wait |-> valley_ok)
      else $error("valley timeout not honoured");
endmodule

// >>> rtl/pfc_timer.sv
/*
 * Switch cycle timer: on-time, minimum off-time, minimum period and the
 * overcurrent blanking window. Single pclk domain.
 */
`timescale 1ns/1ps
module pfc_timer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link to the core
   pfc_sw_if.timer sw
);
   logic [15:0] on_cnt_reg;
   logic [15:0] off_cnt_reg;
   logic [15:0] per_cnt_reg;
   logic gate_reg;
   logic blank_done;
   logic off_ok;
   logic freq_ok;
   logic start_now;
   logic end_now;

   // Overcurrent is masked during the blanking window after turn-on
   assign blank_done = (on_cnt_reg >= 16'(pfc_pkg::BLANK_CYC));
   assign off_ok = (off_cnt_reg >= sw.off_min);
   // Below the minimum period the cycle stretches to a later valley, i.e. DCM
   assign freq_ok = (per_cnt_reg >= sw.per_min);
   assign start_now = !gate_reg && sw.run && off_ok && freq_ok && sw.valley_ok;
   assign end_now = gate_reg && ((on_cnt_reg >= 16'(sw.ton_lim)) || !sw.run ||
      (sw.ocp_hit && blank_done));
   assign sw.gate = gate_reg;
   assign sw.cycle_start = start_now;
   assign sw.cycle_ocp = gate_reg && sw.ocp_hit && blank_done;

   // Gate and counters; off and period counters saturate to avoid wrapping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_reg <= 1'b0;
         on_cnt_reg <= 16'h0000;
         off_cnt_reg <= 16'h0000;
         per_cnt_reg <= 16'h0000;
      end else begin
         if (start_now) gate_reg <= 1'b1;
         else if (end_now) gate_reg <= 1'b0;
         on_cnt_reg <= start_now ? 16'h0000 : (gate_reg ? on_cnt_reg + 16'h0001 : on_cnt_reg);
         off_cnt_reg <= gate_reg ? 16'h0000 :
            ((off_cnt_reg == 16'hFFFF) ? off_cnt_reg : off_cnt_reg + 16'h0001);
         per_cnt_reg <= start_now ? 16'h0000 :
            ((per_cnt_reg == 16'hFFFF) ? per_cnt_reg : per_cnt_reg + 16'h0001);
      end
   end

   a_min_off: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(gate_reg) |-> $past(off_cnt_reg) >= $past(sw.off_min))
      else $error("switch turned on before minimum off time");
   // Soft start may end a stroke early; only overcurrent is masked here
   a_blank_ocp: assert property (@(posedge pclk) disable iff (!presetn)
      gate_reg && !blank_done && sw.run && (on_cnt_reg < 16'(sw.ton_lim)) |=> gate_reg)
      else $error("gate ended inside blanking window");
   a_freq_lim: assert property (@(posedge pclk) disable iff (!presetn)
      start_now |-> per_cnt_reg >= sw.per_min)
      else $error("switching above maximum frequency");
endmodule

// >>> sim/pfc_partner.sv
/* Far side of the switch: demagnetisation and drain ringing.
   Assumes gate from the block; slow withholds valleys. */
`timescale 1ns/1ps
module pfc_partner (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Switch and mode
   input wire logic gate,
   input wire logic slow,
   // Sense lines
   output logic demag,
   output logic valley
);
   int t;
   // Cycles since turn-off
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) t <= 0;
      else t <= gate ? 0 : t + 1;
   end
   // Ringing valley every 8 cycles, so a late turn-on still finds one
   assign demag = !gate && t >= 3;
   assign valley = !gate && !slow && t >= 3 && t % 8 == 5;
endmodule

// >>> sim/tb.sv
/* Bench for pfc_ctrl: APB reads scored from a queue, stroke watch.
   Assumes the partner answers every stroke. */
`timescale 1ns/1ps
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, x = 32'h104C;
   logic [11:0] boost = 12'h0, mains = 12'h0;
   logic ocp = 1'b0, bo = 1'b0, bi = 1'b1, dovp = 1'b0, flt = 1'b0, capacitive_mode_guard = 1'b0;
   logic below = 1'b1, done = 1'b0, ok = 1'b0, slow = 1'b0, pg = 1'b0, dm = 1'b0;
   logic pready, pslverr, demag, valley, nvm_read, gate, llc, xcap, chg;
   logic [64:0] q[$];
   logic [64:0] e;
   logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   logic [31:0] rv[6] = '{32'h1, 32'h800, 32'h14, 32'h64, 32'h30D40, 32'h4};
   int miscompares = 0, checks = 0, off = 0, on = 0, per = 0, n = 0;
   always #25 pclk = ~pclk;
   pfc_ctrl #(.SHORT_COIL_CYC(300)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .boost_sense_input(boost),
      .mains_sense_input(mains), .pfc_current_sense(ocp), .pfc_drain_sense(valley),
      .demag_detect(demag), .ocp_trip(ocp), .brownout_flag(bo), .brownin_flag(bi),
      .drain_ovp_flag(dovp), .fault_flags_any(flt), .cmr_active(capacitive_mode_guard),
      .supply_below_start(below), .nvm_done(done), .nvm_ok(ok), .nvm_read(nvm_read),
      .pfc_gate(gate), .llc_enable(llc), .xcap_discharge(xcap), .supply_charge(chg));
   pfc_partner far_u (.pclk(pclk), .presetn(presetn), .gate(gate), .slow(slow),
      .demag(demag), .valley(valley));
   // ************************************************************
   // Shared tasks
   // ************************************************************
   function automatic logic [31:0] xs(logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task chk(input logic [31:0] ex, input logic [31:0] got);
      checks++;
      if (got !== ex) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   task results();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [64:0] ex);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) q.push_back(ex);
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge, so a following call never drives psel twice in one step
      @(posedge pclk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
      apb(1'b0, a, 32'h0, {1'b0, m, ex});
   endtask
   task wt(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // Level looked at after the edge's updates land
   task lv(input logic ex, input logic got);
      #1 chk({31'h0, ex}, {31'h0, got});
      @(posedge pclk);
   endtask
   task strokes(input int k);
      int i;
      int m;
      m = n + k;
      x = xs(x);
      // Kept below the reference so the on-time limit keeps climbing
      boost <= {2'b00, x[9:0]};
      for (i = 0; i < 3000 && n < m; i++) @(posedge pclk);
      chk(32'h1, 32'(n >= m));
   endtask
   // Read scoreboard: oldest note against the access phase
   always @(posedge pclk) if (psel && penable && !pwrite && pready === 1'b1) begin
      e = q.pop_front();
      chk(e[31:0], prdata & e[63:32]);
      chk({31'h0, e[64]}, {31'h0, pslverr});
   end
   // Stroke watch: off-time, period, demag before turn-on, soft start
   always @(posedge pclk) if (presetn) begin
      if (gate === 1'b1 && pg === 1'b0) begin
         n++;
         chk(32'h1, 32'(off >= 20));
         chk(32'h1, 32'(per >= 100));
         chk(32'h1, {31'h0, dm});
         per = 0;
         on = 0;
      end
      if (gate === 1'b0 && pg === 1'b1) begin
         if (n <= 6) chk(32'h1, 32'(on <= n + 2));
         off = 0;
         dm = 1'b0;
      end
      per++;
      if (gate === 1'b1) on++;
      else off++;
      if (demag === 1'b1) dm = 1'b1;
      pg = gate;
   end
   // Watchdog well beyond the expected run
   initial begin
      #3000000;
      miscompares++;
      results();
   end
   initial begin
      wt(12);
      presetn <= 1'b1;
      x = xs(x);
      mains <= {1'b0, x[26:16]};
      @(posedge pclk);
      foreach (ra[i]) rd(ra[i], rv[i], 32'hFFFFFFFF);
      apb(1'b0, 8'h24, 32'h0, {1'b1, 64'h0});
      apb(1'b0, 8'h02, 32'h0, {1'b1, 64'h0});
      done <= 1'b1;
      wt(6);
      rd(8'h1C, 32'h0, 32'h7);
      rd(8'h18, 32'h1, 32'h1);
      lv(1'b1, nvm_read);
      lv(1'b0, gate);
      ok <= 1'b1;
      below <= 1'b0;
      strokes(8);
      rd(8'h1C, 32'h1, 32'h7);
      apb(1'b1, 8'h18, 32'h1, 65'h0);
      rd(8'h18, 32'h0, 32'h1);
      slow <= 1'b1;
      strokes(2);
      slow <= 1'b0;
      apb(1'b1, 8'h10, 32'h64, 65'h0);
      wt(130);
      lv(1'b1, xcap);
      mains <= mains + 12'h1;
      wt(6);
      lv(1'b0, xcap);
      apb(1'b1, 8'h10, 32'hFFFFFF, 65'h0);
      apb(1'b1, 8'h00, 32'h9, 65'h0);
      bo <= 1'b1;
      bi <= 1'b0;
      wt(8);
      lv(1'b0, llc);
      rd(8'h1C, 32'h20, 32'h30);
      bo <= 1'b0;
      bi <= 1'b1;
      strokes(8);
      ocp <= 1'b1;
      wt(310);
      rd(8'h1C, 32'h2, 32'h7);
      rd(8'h18, 32'h24, 32'h24);
      lv(1'b0, llc);
      below <= 1'b1;
      wt(3);
      lv(1'b1, chg);
      below <= 1'b0;
      ocp <= 1'b0;
      capacitive_mode_guard <= 1'b1;
      wt(12);
      capacitive_mode_guard <= 1'b0;
      rd(8'h1C, 32'h1, 32'h7);
      rd(8'h18, 32'h8, 32'h8);
      flt <= 1'b1;
      wt(8);
      rd(8'h1C, 32'h2, 32'h7);
      flt <= 1'b0;
      wt(12);
      rd(8'h1C, 32'h1, 32'h7);
      apb(1'b1, 8'h00, 32'h3, 65'h0);
      dovp <= 1'b1;
      wt(8);
      dovp <= 1'b0;
      wt(12);
      rd(8'h1C, 32'h3, 32'h17);
      rd(8'h18, 32'h2, 32'h2);
      results();
   end
endmodule
